// ==== usb_far_end.sv ====
// far-side usb event source
module usb_far_end (
  input wire clk_sys,
  output logic [7:0] ev,
  output logic [7:0] error_evt,
  output logic [5:0] token_status,
  output logic bus_idle,
  output logic line_se0
);
  initial {ev, error_evt, token_status, bus_idle, line_se0} = 24'h0;
  task pulse(input [7:0] e, input [7:0] er, input [5:0] st = 6'h0);
    @(posedge clk_sys);
    ev <= e;
    error_evt <= er;
    token_status <= st;
    @(posedge clk_sys);
    {ev, error_evt} <= 16'h0;
    token_status <= ~st;
  endtask
endmodule

// ==== usb_interrupt_error_flags_tb_top.sv ====
// self-checking bench for the usb interrupt and error block
module usb_interrupt_error_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, combined_usb_irq, host_operation_enable;
  logic [3:0] s_axi_awaddr_lo = 4'h0, s_axi_wstrb = 4'hF;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  wire [7:0] ev, error_evt;
  wire [5:0] token_status;
  wire bus_idle, line_se0, bus_reset_evt, detach_evt, attach_evt, stall_evt;
  wire resume_evt, idle_evt, frame_start_evt, token_done_evt;
  int failures = 0, checked = 0, n;
  assign {token_done_evt, frame_start_evt, idle_evt, resume_evt} = ev[7:4];
  assign {stall_evt, attach_evt, detach_evt, bus_reset_evt} = ev[3:0];
  always #10 clk_sys = ~clk_sys;
  usb_irq_core u_usb_irq_core (.*);
  usb_far_end u_usb_far_end (.*);
  task complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    n = 0;
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 0;
    if (n >= 40) begin failures++; complete_run(); end
  endtask
  task rd(input [7:0] a);
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 0;
    if (n >= 40) begin failures++; complete_run(); end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  task wc(input [7:0] a, input [31:0] v, input [31:0] e);
    wr(a, v);
    rc(a, e);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 0;
    rc(8'h04, 32'h0);
    rc(8'h08, 32'h0);
    wc(8'h04, 32'hFFFFFFDF, 32'hDF);
    for (int i = 0; i < 8; i++) begin
      u_usb_far_end.pulse(8'h00, 8'h01 << i);
      rc(8'h08, 32'h1 << i);
      wc(8'h08, 32'hFFFFFF00, 32'h1 << i);
      wc(8'h08, 32'h1 << i, 32'h0);
    end
    $display("error flag test done");
    wc(8'h04, 32'h02, 32'h02);
    u_usb_far_end.pulse(8'h00, 8'h04);
    rc(8'h00, 32'h0);
    chk({31'h0, combined_usb_irq}, 32'h0);
    wc(8'h0C, 32'h04, 32'h04);
    rc(8'h00, 32'h02);
    chk({31'h0, combined_usb_irq}, 32'h1);
    wc(8'h04, 32'h0, 32'h0);
    chk({31'h0, combined_usb_irq}, 32'h0);
    wc(8'h08, 32'h04, 32'h0);
    rc(8'h00, 32'h0);
    $display("summary error test done");
    u_usb_far_end.pulse(8'h01, 8'h00);
    rc(8'h00, 32'h01);
    wc(8'h04, 32'h01, 32'h01);
    chk({31'h0, combined_usb_irq}, 32'h1);
    wc(8'h00, 32'h01, 32'h0);
    chk({31'h0, combined_usb_irq}, 32'h0);
    wc(8'h10, 32'h01, 32'h01);
    chk({31'h0, host_operation_enable}, 32'h1);
    u_usb_far_end.pulse(8'h06, 8'h02);
    rc(8'h00, 32'h01);
    chk({31'h0, combined_usb_irq}, 32'h1);
    rc(8'h08, 32'h02);
    wr(8'h08, 32'h02);
    wr(8'h00, 32'h01);
    u_usb_far_end.bus_idle <= 1;
    repeat (140) @(posedge clk_sys);
    u_usb_far_end.pulse(8'h04, 8'h00);
    rc(8'h00, 32'h40);
    wr(8'h00, 32'h40);
    u_usb_far_end.line_se0 <= 1;
    repeat (4) @(posedge clk_sys);
    u_usb_far_end.pulse(8'h04, 8'h00);
    rc(8'h00, 32'h0);
    u_usb_far_end.line_se0 <= 0;
    $display("reset detach attach test done");
    u_usb_far_end.pulse(8'h80, 8'h00, 6'h2D);
    u_usb_far_end.pulse(8'h80, 8'h00, 6'h13);
    rc(8'h00, 32'h08);
    rc(8'h14, 32'hB4);
    wr(8'h00, 32'h08);
    rc(8'h14, 32'h4C);
    rd(8'h40);
    chk({30'h0, r}, 32'h2);
    $display("token and unmapped test done");
    complete_run();
  end
endmodule

// ==== usb_irq_checker.sv ====
// port-level assertions for the usb interrupt and error block
module usb_irq_checker (
  input wire clk_sys,
  input wire srst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire combined_usb_irq,
  input wire host_operation_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read answer late");
  property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
  a_bans: assert property (p_bans) else $error("write answer late");
  property p_busy; (!s_axi_bvalid || !s_axi_awready) && (!s_axi_rvalid || !s_axi_arready); endproperty
  a_busy: assert property (p_busy) else $error("request taken while busy");
  property p_resp; s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2; endproperty
  a_resp: assert property (p_resp) else $error("bad read response code");
  property p_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_fall; $fell(combined_usb_irq) |-> $past(s_axi_wready, 2) || $past(s_axi_wready, 3) || $past(s_axi_wready, 4); endproperty
  a_fall: assert property (p_fall) else $error("request dropped without write");
  property p_host; $changed(host_operation_enable) |-> $past(s_axi_wready, 2) || $past(s_axi_wready, 3); endproperty
  a_host: assert property (p_host) else $error("host enable moved alone");
  c_irq: cover property ($rose(combined_usb_irq));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_host: cover property ($rose(host_operation_enable));
endmodule
bind usb_irq_core usb_irq_checker u_usb_irq_checker (.*);

// ==== usb_irq_core.v ====
// usb interrupt flags, enables and error flags behind an axi4-lite slave
// Summary of operation
// - device mode: flag bit 0 set on valid bus reset from host
// - host mode: flag bit 0 set on peripheral detach
// - attach flag valid only with host enabled, 2.5 us idle, no se0
// - clearing token-complete flag advances the transfer status fifo
// - summary error flag set only by enabled error conditions
// - enable register: eight r/w enables, reset zero
// - errors reach combined request only when irq enable bit 1 set
// - enable bit 0 gates bus-reset in device, detach in host mode
// - error flags hardware set, reset zero, cleared by writing one
// - error bit 7: bit stuffing violation
// - error bit 6: invalid descriptor or buffer address
// - error bit 5: memory access late or packet truncated
// - error bit 4: bus turnaround time-out
// - error bit 3: data field not whole bytes
// - error bit 2: data crc16 failure
// - device mode error bit 1: token crc5 failure
// - host mode error bit 1: end-of-frame error
// - error bit 0: packet identifier check failure
// - bits 31..8 of enable and error registers read zero
// - token-complete flag set when token processing finishes
`include "usb_irq_defs.vh"
module usb_irq_core #(
  parameter FIFO_DEPTH = 4,
  parameter FIFO_AW = 2
) (
  input wire clk_sys,
  input wire srst,
  input wire [3:0] s_axi_awaddr_lo,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire bus_reset_evt,
  input wire detach_evt,
  input wire attach_evt,
  input wire bus_idle,
  input wire line_se0,
  input wire stall_evt,
  input wire resume_evt,
  input wire idle_evt,
  input wire frame_start_evt,
  input wire token_done_evt,
  input wire [5:0] token_status,
  input wire [7:0] error_evt,
  output reg combined_usb_irq,
  output reg host_operation_enable
);
  reg [7:0] usb_irq_flags_r;
  reg [7:0] usb_irq_enable_r;
  reg [7:0] usb_error_status_r;
  reg [7:0] usb_error_enable_r;
  reg suspend_r;
  reg [5:0] fifo_mem [0:FIFO_DEPTH-1];
  reg [FIFO_AW-1:0] wr_ptr_r;
  reg [FIFO_AW-1:0] rd_ptr_r;
  reg [FIFO_AW:0] count_r;
  reg [11:0] idle_cnt_r;
  reg [1:0] idle_s_r;
  reg [1:0] se0_s_r;
  reg [7:0] aw_addr_r;
  reg aw_have_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_have_r;
  wire do_write;
  wire [7:0] wmask;
  wire [7:0] err_set;
  wire [7:0] flag_set;
  wire [7:0] flag_clr;
  wire attach_ok;
  wire fifo_pop;
  wire fifo_push;
  wire wr_hit_flags;
  reg [31:0] rd_mux;
  reg rd_ok;
  reg [7:0] irq_enable_nxt;

  assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wmask = w_strb_r[0] ? w_data_r[7:0] : 8'h00;
  assign wr_hit_flags = do_write && (aw_addr_r == `OFS_IRQ_FLAGS);

  // bus line levels cross from the transceiver domain
  always @(posedge clk_sys) begin
    if (srst) begin
      idle_s_r <= 2'h0;
      se0_s_r <= 2'h0;
    end else begin
      idle_s_r <= {idle_s_r[0], bus_idle};
      se0_s_r <= {se0_s_r[0], line_se0};
    end
  end

  // idle time counter for attach qualification
  always @(posedge clk_sys) begin
    if (srst || !idle_s_r[1]) begin
      idle_cnt_r <= 12'h000;
    end else if (idle_cnt_r < `IDLE_ATTACH_CYC) begin
      idle_cnt_r <= idle_cnt_r + 12'h001;
    end
  end
  assign attach_ok = attach_evt && host_operation_enable &&
                     (idle_cnt_r >= `IDLE_ATTACH_CYC) && !se0_s_r[1];

  // error status register
  assign err_set = error_evt;
  always @(posedge clk_sys) begin
    if (srst) begin
      usb_error_status_r <= `RST_BYTE;
    end else begin
      usb_error_status_r <= err_set |
        (usb_error_status_r & ~((do_write && aw_addr_r == `OFS_ERR_STATUS) ? wmask : 8'h00));
    end
  end

  // flag register set terms
  assign flag_set = {stall_evt, attach_ok, resume_evt, idle_evt, token_done_evt,
                     frame_start_evt,
                     |(usb_error_status_r & usb_error_enable_r),
                     host_operation_enable ? detach_evt : bus_reset_evt};
  assign flag_clr = wr_hit_flags ? (wmask & 8'hFD) : 8'h00;

  always @(posedge clk_sys) begin
    if (srst) begin
      usb_irq_flags_r <= `RST_BYTE;
    end else begin
      usb_irq_flags_r <= flag_set | (usb_irq_flags_r & ~flag_clr);
      usb_irq_flags_r[`BIT_ERROR] <= flag_set[`BIT_ERROR];
    end
  end

  // token status fifo
  assign fifo_push = token_done_evt && (count_r != FIFO_DEPTH);
  assign fifo_pop = flag_clr[`BIT_TOKEN] && usb_irq_flags_r[`BIT_TOKEN] &&
                    (count_r != 0);
  always @(posedge clk_sys) begin
    if (srst) begin
      wr_ptr_r <= {FIFO_AW{1'b0}};
      rd_ptr_r <= {FIFO_AW{1'b0}};
      count_r <= {(FIFO_AW+1){1'b0}};
    end else begin
      if (fifo_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (fifo_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (fifo_push && !fifo_pop) begin
        count_r <= count_r + 1'b1;
      end else if (fifo_pop && !fifo_push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
  always @(posedge clk_sys) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr_r] <= token_status;
    end
  end

  // control registers
  always @* begin
    irq_enable_nxt = usb_irq_enable_r;
    if (do_write && aw_addr_r == `OFS_IRQ_ENABLE && w_strb_r[0]) begin
      irq_enable_nxt = w_data_r[7:0];
    end
  end
  always @(posedge clk_sys) begin
    if (srst) begin
      usb_irq_enable_r <= `RST_BYTE;
      usb_error_enable_r <= `RST_BYTE;
      host_operation_enable <= 1'b0;
      suspend_r <= 1'b0;
    end else begin
      usb_irq_enable_r <= irq_enable_nxt;
      if (do_write && aw_addr_r == `OFS_ERR_ENABLE && w_strb_r[0]) begin
        usb_error_enable_r <= w_data_r[7:0];
      end
      if (do_write && aw_addr_r == `OFS_MODE_CTRL && w_strb_r[0]) begin
        host_operation_enable <= w_data_r[`BIT_HOST_EN];
        suspend_r <= w_data_r[`BIT_SUSPEND];
      end
    end
  end

  // combined request; bit 0 enable covers reset or detach by mode, bit 1 covers errors
  always @(posedge clk_sys) begin
    if (srst) begin
      combined_usb_irq <= 1'b0;
    end else begin
      combined_usb_irq <= |(usb_irq_flags_r & usb_irq_enable_r);
    end
  end

  // axi write channel
  always @(posedge clk_sys) begin
    if (srst) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r <= `OFS_MODE_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read decode; upper bits read zero
  always @* begin
    rd_ok = 1'b1;
    rd_mux = 32'h00000000;
    case ({s_axi_araddr[7:2], 2'b00})
      `OFS_IRQ_FLAGS: rd_mux[7:0] = usb_irq_flags_r;
      `OFS_IRQ_ENABLE: rd_mux[7:0] = usb_irq_enable_r;
      `OFS_ERR_STATUS: rd_mux[7:0] = usb_error_status_r;
      `OFS_ERR_ENABLE: rd_mux[7:0] = usb_error_enable_r;
      `OFS_MODE_CTRL: rd_mux[1:0] = {suspend_r, host_operation_enable};
      `OFS_STAT_FIFO: rd_mux[7:2] = (count_r != 0) ? fifo_mem[rd_ptr_r] : 6'h00;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== usb_irq_defs.vh ====
// register offsets, bit positions, reset values and timing for the usb interrupt and error logic
`ifndef USB_IRQ_DEFS_VH
`define USB_IRQ_DEFS_VH
`define OFS_IRQ_FLAGS 8'h00
`define OFS_IRQ_ENABLE 8'h04
`define OFS_ERR_STATUS 8'h08
`define OFS_ERR_ENABLE 8'h0C
`define OFS_MODE_CTRL 8'h10
`define OFS_STAT_FIFO 8'h14
`define BIT_RESET_DETACH 0
`define BIT_ERROR 1
`define BIT_TOKEN 3
`define BIT_ATTACH 6
`define BIT_HOST_EN 0
`define BIT_SUSPEND 1
`define RST_BYTE 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define IDLE_ATTACH_NS 2500
`define CLK_PERIOD_NS 20
`define IDLE_ATTACH_CYC ((`IDLE_ATTACH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif
